/* dpioc_edge_det.sv */
// dpioc_edge_det: two-stage synchroniser and edge detector for port3 inputs
// assumes raw pins asynchronous; edges seen in the same cycle the second stage takes the new level
`timescale 1ns/1ps
module dpioc_edge_det (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // raw pins
   input wire logic [2:0] pin_i,
   // synchronised results
   dpioc_if.det det
);
   import dpioc_pkg::*;
   logic [2:0] meta;
   logic [2:0] sync;
   logic [2:0] last;
   logic [SYNC_STAGES:0] fill;

   // first stage read only by the second
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         meta <= 3'h0;
         sync <= 3'h0;
         last <= 3'h0;
         fill <= '0;
      end else begin
         fill <= {fill[SYNC_STAGES-1:0], 1'b1};
         meta <= pin_i;
         sync <= meta;
         last <= sync;
      end
   end

   assign det.pin_sync = sync;
   // edges masked until the last stage holds a real sample, not reset zeros
   assign det.edge_rise = sync & ~last & {3{fill[SYNC_STAGES]}};
   assign det.edge_fall = ~sync & last & {3{fill[SYNC_STAGES]}};

   a_edge_after_sync: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      det.edge_fall[2] |-> $past(sync[2]) && !sync[2])
      else $error("falling edge without synchronised change");
endmodule : dpioc_edge_det

/* dpioc_if.sv */
// dpioc_if: synchronised port3 inputs passed from the edge detector
// assumes the same clock domain as the top module
`timescale 1ns/1ps
interface dpioc_if;
   logic [2:0] pin_sync;
   logic [2:0] edge_rise;
   logic [2:0] edge_fall;
   modport det (output pin_sync, output edge_rise, output edge_fall);
   modport use_side (input pin_sync, input edge_rise, input edge_fall);
endinterface : dpioc_if

/* dpioc_pin_model.sv */
// dpioc_pin_model: board wiring on the port pins
// assumes pull-ups on port 2 lines and a board driver on line 4
`timescale 1ns/1ps
module dpioc_pin_model (
   // design drive
   input wire logic [7:0] p2_drv_i,
   input wire logic [7:0] p2_oe_i,
   input wire logic p34_drv_i,
   input wire logic p34_oe_i,
   // board drive
   input wire logic [7:0] ext_p2_i,
   input wire logic [7:0] ext_oe_i,
   input wire logic ext_p34_i,
   // resolved levels
   output logic [7:0] p2_wire_o,
   output logic p34_wire_o
);
   // released lines sit at the pull-up, so open-drain highs read 1
   always_comb begin
      for (int k = 0; k < 8; k++) begin
         p2_wire_o[k] = p2_oe_i[k] ? p2_drv_i[k] : (ext_oe_i[k] ? ext_p2_i[k] : 1'b1);
      end
   end
   // slave clock comes from the board once line 4 is released
   assign p34_wire_o = p34_oe_i ? p34_drv_i : ext_p34_i;
endmodule : dpioc_pin_model

/* dpioc_pkg.sv */
// dpioc_pkg: constants for the dual port i/o block with comparators
// assumes a single 40 MHz system clock and synchronous reset
package dpioc_pkg;
   localparam int P2_WIDTH = 8;
   localparam int P2_SDI_BIT = 0;
   localparam int P2_SDO_BIT = 7;
   // port3_mode_reg fields
   localparam int MODE_ANALOG_BIT = 1;
   localparam int MODE_WIDTH = 8;
   localparam logic [7:0] MODE_RESET = 8'h00;
   // port_config_reg fields
   localparam int CFG_CMP_OUT_BIT = 0;
   localparam int CFG_LEMI_P2_BIT = 5;
   localparam int CFG_LEMI_P3_BIT = 6;
   localparam int CFG_LEMI_OSC_BIT = 7;
   localparam logic [7:0] CFG_RESET = 8'hfe;
   // interrupt edge select bits
   localparam int IRQ_EDGE_LO_BIT = 6;
   localparam int IRQ_EDGE_HI_BIT = 7;
   typedef enum logic [1:0] {
      DPIOC_EDGE_FALL = 2'h0,
      DPIOC_EDGE_RISE = 2'h1,
      DPIOC_EDGE_BOTH = 2'h2,
      DPIOC_EDGE_BOTH2 = 2'h3
   } dpioc_edge_t;
   localparam int SYNC_STAGES = 2;
endpackage : dpioc_pkg

/* dpioc_top.sv */
// dpioc_top: dual general purpose port with comparators and edge interrupts
// assumes analog comparator results arrive as digital levels; serial and timer
// peripherals live outside and hand over their pin signals here.
// Overview of operation
// - eight-line first port, each line input or output on its own
// - one global setting picks push-pull or open-drain for first-port outputs
// - serial enabled: line 0 is data in, line 7 is data out
// - second port: lines 1-3 fixed inputs, lines 4-6 push-pull outputs
// - comparator mode only when mode register bit D1 is set
// - lines 1 and 2 interrupt on falling, rising or both edges
// - line 3 interrupts on falling edge, digital mode only
// - lines 1 and 2 interrupt in both modes; line 1 feeds timer
// - config bit D0 drives comparator results to lines 4 and 5
// - serial enabled: line 4 serial clock, line 5 slave select in slave
// - undriven first-port inputs read the pin level, sampled in three stages
// - analog mode: lines 1,2 positive inputs, line 3 common reference
// - digital mode: line 3 readable and usable as interrupt source three
// - oscillator and both ports low-emission mode independently
// - timer input from line 1, timer output on line 6
// - config bit 0 low-emission, 1 standard; bits 5-7 reset to 1
`timescale 1ns/1ps
module dpioc_top #(
   parameter int P2W = dpioc_pkg::P2_WIDTH
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // configuration from the core
   input wire logic [P2W-1:0] p2_dir_out_i,
   input wire logic p2_open_drain_i,
   input wire logic [P2W-1:0] p2_data_out_i,
   input wire logic [2:0] p3_data_out_i,
   input wire logic [dpioc_pkg::MODE_WIDTH-1:0] port3_mode_reg_i,
   input wire logic port3_mode_we_i,
   input wire logic [7:0] port_config_reg_i,
   input wire logic port_config_we_i,
   input wire logic [7:0] irq_ctrl_i,
   // peripheral hand-over
   input wire logic spi_en_i,
   input wire logic spi_master_i,
   input wire logic spi_sdo_i,
   input wire logic spi_sdo_en_i,
   input wire logic spi_clk_out_i,
   input wire logic timer_out_i,
   input wire logic [1:0] cmp_result_i,
   // pins
   input wire logic [P2W-1:0] p2_pin_i,
   output logic [P2W-1:0] p2_pin_o,
   output logic [P2W-1:0] p2_pin_oe_o,
   input wire logic [2:0] p3_in_pin_i,
   output logic [2:0] p3_out_pin_o,
   output logic p34_oe_o,
   output logic p35_oe_o,
   input wire logic p34_pin_i,
   input wire logic p35_pin_i,
   // results to the core
   output logic [P2W-1:0] p2_read_o,
   output logic [2:0] p3_read_o,
   output logic [2:0] irq_o,
   output logic analog_mode_o,
   output logic [2:0] cmp_in_sel_o,
   output logic timer_in_o,
   output logic serial_data_in_pin_o,
   output logic serial_clock_pin_o,
   output logic slave_select_o,
   output logic [2:0] low_emi_o
);
   import dpioc_pkg::*;

   logic [MODE_WIDTH-1:0] port3_mode_reg;
   logic [7:0] port_config_reg;
   logic [P2W-1:0] p2_meta;
   logic [P2W-1:0] p2_sync;
   logic [P2W-1:0] p2_hold;
   logic analog;
   logic cmp_out_en;
   logic [P2W-1:0] next_p2_pin;
   logic [P2W-1:0] next_p2_oe;
   logic [2:0] next_p3_out;
   logic next_p34_oe;
   logic next_p35_oe;
   logic serial_slave;
   logic [2:0] next_irq;
   dpioc_if sync_if ();

   function automatic logic edge_hit(input dpioc_edge_t sel, input logic r, input logic f);
      case (sel)
         DPIOC_EDGE_FALL: edge_hit = f;
         DPIOC_EDGE_RISE: edge_hit = r;
         default: edge_hit = r | f;
      endcase
   endfunction : edge_hit

   dpioc_edge_det u_edge (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .pin_i(p3_in_pin_i),
      .det(sync_if.det)
   );

   // mode and config registers
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         port3_mode_reg <= MODE_RESET;
         port_config_reg <= CFG_RESET;
      end else begin
         if (port3_mode_we_i) begin
            port3_mode_reg <= port3_mode_reg_i;
         end
         if (port_config_we_i) begin
            port_config_reg <= port_config_reg_i;
         end
      end
   end

   assign analog = port3_mode_reg[MODE_ANALOG_BIT];
   assign cmp_out_en = port_config_reg[CFG_CMP_OUT_BIT];
   // in slave mode line 5 is released and read as the select input
   assign serial_slave = spi_en_i & ~spi_master_i;

   // port 2 input sampling; hold is a third stage that takes sync every cycle
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         p2_meta <= '0;
         p2_sync <= '0;
         p2_hold <= '0;
      end else begin
         p2_meta <= p2_pin_i;
         p2_sync <= p2_meta;
         p2_hold <= p2_sync;
      end
   end

   // port 2 drive
   always_comb begin
      for (int i = 0; i < P2W; i++) begin
         next_p2_pin[i] = p2_data_out_i[i];
         next_p2_oe[i] = p2_dir_out_i[i];
         if (p2_open_drain_i && p2_dir_out_i[i]) begin
            next_p2_pin[i] = 1'b0;
            next_p2_oe[i] = ~p2_data_out_i[i];
         end
      end
      if (spi_en_i) begin
         next_p2_oe[P2_SDI_BIT] = 1'b0;
         next_p2_pin[P2_SDI_BIT] = 1'b0;
         next_p2_pin[P2_SDO_BIT] = spi_sdo_i;
         next_p2_oe[P2_SDO_BIT] = spi_sdo_en_i;
      end
   end

   // port 3 outputs: lines 4,5,6 as bits 0,1,2
   always_comb begin
      next_p3_out = p3_data_out_i;
      next_p34_oe = 1'b1;
      next_p35_oe = 1'b1;
      if (cmp_out_en) begin
         next_p3_out[1:0] = cmp_result_i;
      end
      if (spi_en_i) begin
         next_p3_out[0] = spi_clk_out_i;
         next_p34_oe = spi_master_i;
         next_p35_oe = spi_master_i;
      end
      next_p3_out[2] = timer_out_i;
   end

   // interrupt requests, one cycle pulse per edge
   always_comb begin
      next_irq[0] = edge_hit(dpioc_edge_t'(irq_ctrl_i[IRQ_EDGE_HI_BIT:IRQ_EDGE_LO_BIT]),
                             sync_if.edge_rise[0], sync_if.edge_fall[0]);
      next_irq[1] = edge_hit(dpioc_edge_t'(irq_ctrl_i[IRQ_EDGE_HI_BIT:IRQ_EDGE_LO_BIT]),
                             sync_if.edge_rise[1], sync_if.edge_fall[1]);
      next_irq[2] = sync_if.edge_fall[2] & ~analog;
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         p2_pin_o <= '0;
         p2_pin_oe_o <= '0;
         p3_out_pin_o <= 3'h0;
         p34_oe_o <= 1'b1;
         p35_oe_o <= 1'b1;
         irq_o <= 3'h0;
      end else begin
         p2_pin_o <= next_p2_pin;
         p2_pin_oe_o <= next_p2_oe;
         p3_out_pin_o <= next_p3_out;
         p34_oe_o <= next_p34_oe;
         p35_oe_o <= next_p35_oe;
         irq_o <= next_irq;
      end
   end

   // read-back and peripheral feeds
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         p2_read_o <= '0;
         p3_read_o <= 3'h0;
         analog_mode_o <= 1'b0;
         cmp_in_sel_o <= 3'h0;
         timer_in_o <= 1'b0;
         serial_data_in_pin_o <= 1'b0;
         serial_clock_pin_o <= 1'b0;
         slave_select_o <= 1'b1;
         low_emi_o <= 3'h0;
      end else begin
         p2_read_o <= p2_hold;
         p3_read_o <= sync_if.pin_sync;
         if (analog) begin
            p3_read_o[2] <= 1'b0;
         end
         analog_mode_o <= analog;
         cmp_in_sel_o <= analog ? 3'h7 : 3'h0;
         timer_in_o <= sync_if.pin_sync[0];
         serial_data_in_pin_o <= spi_en_i & p2_hold[P2_SDI_BIT];
         serial_clock_pin_o <= spi_en_i & (spi_master_i ? spi_clk_out_i : p34_pin_i);
         slave_select_o <= serial_slave ? p35_pin_i : 1'b1;
         low_emi_o <= ~{port_config_reg[CFG_LEMI_OSC_BIT], port_config_reg[CFG_LEMI_P3_BIT],
                        port_config_reg[CFG_LEMI_P2_BIT]};
      end
   end

   // all checks sample on the system clock; the assertions sleep through reset, the covers do not
   a_irq3_digital: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      irq_o[2] |-> !$past(analog))
      else $error("line 3 interrupt raised in analog mode");
   a_sdo_follow: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      spi_en_i && spi_sdo_en_i |=> p2_pin_o[P2_SDO_BIT] == $past(spi_sdo_i))
      else $error("serial data out not on line 7");
   a_sdi_input: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      spi_en_i |=> !p2_pin_oe_o[P2_SDI_BIT])
      else $error("serial data in line driven");
   a_open_drain_high: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      p2_open_drain_i && p2_dir_out_i[1] && !spi_en_i |=> p2_pin_o[1] == 1'b0)
      else $error("open drain line drove high");
   a_input_undriven: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      !p2_dir_out_i[3] |=> !p2_pin_oe_o[3])
      else $error("input line driven");
   a_cmp_out_route: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      cmp_out_en && !spi_en_i |=> p3_out_pin_o[1:0] == $past(cmp_result_i))
      else $error("comparator result not on lines 4,5");
   a_timer_out: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      1'b1 |=> p3_out_pin_o[2] == $past(timer_out_i))
      else $error("timer output not on line 6");
   a_low_emi_map: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      port_config_we_i ##1 !port_config_we_i |=>
      low_emi_o[1] == !$past(port_config_reg_i[CFG_LEMI_P3_BIT], 2))
      else $error("low emission mapping wrong");
   a_interrupt_source_one_fall: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      sync_if.edge_fall[0] && irq_ctrl_i[IRQ_EDGE_HI_BIT:IRQ_EDGE_LO_BIT] == 2'h0 |=> irq_o[0])
      else $error("falling edge interrupt missed");
   a_low_emi_p2: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      port_config_we_i ##1 !port_config_we_i |=>
      low_emi_o[0] == !$past(port_config_reg_i[CFG_LEMI_P2_BIT], 2))
      else $error("first port low emission mapping wrong");
   a_low_emi_osc: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      port_config_we_i ##1 !port_config_we_i |=>
      low_emi_o[2] == !$past(port_config_reg_i[CFG_LEMI_OSC_BIT], 2))
      else $error("oscillator low emission mapping wrong");
   a_slave_select_in: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      spi_en_i && !spi_master_i |=> !p35_oe_o && slave_select_o == $past(p35_pin_i))
      else $error("slave select not taken from line 5");
   a_sck_release: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      spi_en_i && !spi_master_i |=> !p34_oe_o)
      else $error("slave drove the serial clock line");
   a_port3_drive: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      !spi_en_i |=> p34_oe_o && p35_oe_o)
      else $error("second port output not driven");
   a_analog_read_zero: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      analog |=> !p3_read_o[2])
      else $error("line 3 read back in analog mode");
   a_analog_flag: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      analog |=> analog_mode_o && cmp_in_sel_o == 3'h7)
      else $error("comparator inputs not selected in analog mode");
   a_timer_in_follow: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      1'b1 |=> timer_in_o == $past(sync_if.pin_sync[0]))
      else $error("timer input not from line 1");
   a_irq2_fall: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      sync_if.edge_fall[1] && irq_ctrl_i[IRQ_EDGE_HI_BIT:IRQ_EDGE_LO_BIT] == 2'h0 |=> irq_o[1])
      else $error("line 2 falling edge interrupt missed");
   a_interrupt_source_one_rise: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      sync_if.edge_rise[0] && irq_ctrl_i[IRQ_EDGE_HI_BIT:IRQ_EDGE_LO_BIT] == 2'h1 |=> irq_o[0])
      else $error("rising edge interrupt missed");
   a_sdi_capture: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      spi_en_i |=> serial_data_in_pin_o == $past(p2_hold[P2_SDI_BIT]))
      else $error("serial data in not taken from line 0");
   a_p2_read_hold: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      1'b1 |=> p2_read_o == $past(p2_hold))
      else $error("first port read not from held level");
   a_push_pull_drive: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      !p2_open_drain_i && p2_dir_out_i[2] |=> p2_pin_oe_o[2] && p2_pin_o[2] == $past(p2_data_out_i[2]))
      else $error("push-pull output not driven");

   c_analog: cover property (@(posedge clk_sys_i) analog && irq_o[0]);
   c_spi_slave: cover property (@(posedge clk_sys_i) spi_en_i && !spi_master_i && !slave_select_o);
   c_irq3: cover property (@(posedge clk_sys_i) irq_o[2]);
   c_open_drain: cover property (@(posedge clk_sys_i) p2_open_drain_i && p2_pin_oe_o[0]);
   c_cmp_out: cover property (@(posedge clk_sys_i) cmp_out_en && p3_out_pin_o[0]);
endmodule : dpioc_top

/* tb_dual_port_io_with_comparators.sv */
// tb_dual_port_io_with_comparators: directed checks of the port block
// assumes the pin model resolves the shared lines
`timescale 1ns/1ps
module tb_dual_port_io_with_comparators;
   import dpioc_pkg::*;
   logic clk_sys_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [7:0] p2_dir_out_i = 8'h00, p2_data_out_i = 8'h00, port3_mode_reg_i = 8'h00;
   logic [7:0] port_config_reg_i = 8'h00, irq_ctrl_i = 8'h00, ext = 8'h00, ext_oe = 8'h00;
   logic p2_open_drain_i = 1'b0, port3_mode_we_i = 1'b0, port_config_we_i = 1'b0, spi_en_i = 1'b0;
   logic spi_master_i = 1'b0, spi_sdo_i = 1'b0, spi_sdo_en_i = 1'b0, spi_clk_out_i = 1'b0;
   logic timer_out_i = 1'b0, ext34 = 1'b0, p35_pin_i = 1'b1;
   logic [2:0] p3_data_out_i = 3'h0, p3_in_pin_i = 3'h7;
   logic [1:0] cmp_result_i = 2'h0;
   logic [7:0] p2_pin_i, p2_pin_o, p2_pin_oe_o, p2_read_o;
   logic [2:0] p3_out_pin_o, p3_read_o, irq_o, cmp_in_sel_o, low_emi_o;
   logic p34_oe_o, p34_pin_i, analog_mode_o, timer_in_o, serial_data_in_pin_o, serial_clock_pin_o;
   logic slave_select_o, p35_oe_o;
   logic [7:0] cnt [3];
   int errors = 0;
   int samples_checked = 0;
   dpioc_top dpioc_top_inst (.clk_sys_i, .sys_rst_i, .p2_dir_out_i, .p2_open_drain_i, .p2_data_out_i,
      .p3_data_out_i, .port3_mode_reg_i, .port3_mode_we_i, .port_config_reg_i, .port_config_we_i,
      .irq_ctrl_i, .spi_en_i, .spi_master_i, .spi_sdo_i, .spi_sdo_en_i, .spi_clk_out_i, .timer_out_i,
      .cmp_result_i, .p2_pin_i, .p2_pin_o, .p2_pin_oe_o, .p3_in_pin_i, .p3_out_pin_o, .p34_oe_o,
      .p34_pin_i, .p2_read_o, .p3_read_o, .irq_o, .analog_mode_o, .cmp_in_sel_o, .timer_in_o,
      .serial_data_in_pin_o, .serial_clock_pin_o, .slave_select_o, .low_emi_o, .p35_pin_i, .p35_oe_o);
   dpioc_pin_model dpioc_pin_model_inst (.p2_drv_i(p2_pin_o), .p2_oe_i(p2_pin_oe_o),
      .p34_drv_i(p3_out_pin_o[0]), .p34_oe_i(p34_oe_o), .ext_p2_i(ext), .ext_oe_i(ext_oe),
      .ext_p34_i(ext34), .p2_wire_o(p2_pin_i), .p34_wire_o(p34_pin_i));
   initial begin
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   // pulse tally per line, so edge counts do not depend on polling
   always @(posedge clk_sys_i) begin
      for (int k = 0; k < 3; k++) begin
         cnt[k] <= sys_rst_i ? 8'h00 : cnt[k] + {7'h00, irq_o[k] === 1'b1};
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask : wt
   task automatic wr(input logic sel, input logic [7:0] v);
      @(posedge clk_sys_i);
      port_config_reg_i <= v;
      port3_mode_reg_i <= v;
      port_config_we_i <= sel;
      port3_mode_we_i <= ~sel;
      @(posedge clk_sys_i);
      port_config_we_i <= 1'b0;
      port3_mode_we_i <= 1'b0;
      wt(2);
   endtask : wr
   task automatic pins(input logic [2:0] v);
      @(posedge clk_sys_i);
      p3_in_pin_i <= v;
      wt(6);
   endtask : pins
   task automatic t_reset;
      chk({3'h0, low_emi_o, slave_select_o, p34_oe_o}, 8'h03);
   endtask : t_reset
   task automatic t_port2;
      @(posedge clk_sys_i);
      p2_dir_out_i <= 8'h0f;
      p2_data_out_i <= 8'ha5;
      ext <= 8'h30;
      ext_oe <= 8'hf0;
      wt(5);
      chk(p2_pin_oe_o, 8'h0f);
      chk(p2_read_o, 8'h35);
      @(posedge clk_sys_i);
      p2_open_drain_i <= 1'b1;
      p2_data_out_i <= 8'h0a;
      wt(5);
      chk(p2_pin_oe_o, 8'h05);
      chk(p2_pin_o & 8'h0f, 8'h00);
      chk(p2_read_o, 8'h3a);
   endtask : t_port2
   task automatic t_edges;
      logic [7:0] r0, r1;
      for (int m = 0; m < 4; m++) begin
         @(posedge clk_sys_i);
         irq_ctrl_i <= {2'(m), 6'h00};
         pins(3'h4);
         r0 = cnt[0];
         r1 = cnt[1];
         pins(3'h7);
         chk(cnt[0] - r0, {7'h00, m != 0});
         chk(cnt[1] - r1, {7'h00, m != 0});
         r0 = cnt[0];
         pins(3'h4);
         chk(cnt[0] - r0, {7'h00, m != 1});
      end
   endtask : t_edges
   task automatic t_line3;
      logic [7:0] r0, r2;
      @(posedge clk_sys_i);
      irq_ctrl_i <= 8'h00;
      pins(3'h7);
      r2 = cnt[2];
      pins(3'h3);
      chk(cnt[2] - r2, 8'h01);
      chk({5'h00, p3_read_o}, 8'h03);
      pins(3'h7);
      chk(cnt[2] - r2, 8'h01);
      wr(1'b0, 8'h02);
      chk({4'h0, analog_mode_o, cmp_in_sel_o}, 8'h0f);
      r0 = cnt[0];
      r2 = cnt[2];
      pins(3'h2);
      chk(cnt[0] - r0, 8'h01);
      chk(cnt[2] - r2, 8'h00);
      chk({5'h00, p3_read_o}, 8'h02);
      pins(3'h3);
      chk({7'h00, timer_in_o}, 8'h01);
      wr(1'b0, 8'h00);
      chk({7'h00, analog_mode_o}, 8'h00);
   endtask : t_line3
   task automatic t_outs;
      @(posedge clk_sys_i);
      cmp_result_i <= 2'h2;
      p3_data_out_i <= 3'h5;
      timer_out_i <= 1'b1;
      wr(1'b1, 8'h01);
      chk({5'h00, p3_out_pin_o}, 8'h06);
      wr(1'b1, 8'h00);
      chk({2'h0, low_emi_o, p3_out_pin_o}, 8'h3d);
      wr(1'b1, 8'ha0);
      chk({5'h00, low_emi_o}, 8'h02);
   endtask : t_outs
   task automatic t_serial;
      @(posedge clk_sys_i);
      {spi_en_i, spi_sdo_i, spi_sdo_en_i, ext34} <= 4'hf;
      p2_dir_out_i <= 8'h00;
      {ext, ext_oe} <= 16'h0101;
      p35_pin_i <= 1'b0;
      wt(5);
      chk({p2_pin_oe_o[7], p2_pin_o[7], serial_data_in_pin_o, serial_clock_pin_o, p34_oe_o}, 8'h1e);
      chk({6'h00, p35_oe_o, slave_select_o}, 8'h00);
      @(posedge clk_sys_i);
      {ext[0], ext34, spi_master_i, spi_clk_out_i} <= 4'h3;
      wt(4);
      chk({serial_data_in_pin_o, p34_oe_o, p3_out_pin_o[0]}, 8'h03);
      chk({5'h00, serial_clock_pin_o, p35_oe_o, slave_select_o}, 8'h07);
   endtask : t_serial
   task automatic summarize;
      if (errors == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : summarize
   initial begin
      repeat (2) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      wt(2);
      t_reset();
      t_port2();
      t_edges();
      t_line3();
      t_outs();
      t_serial();
      summarize();
   end
   initial begin
      #50us;
      errors++;
      summarize();
   end
endmodule : tb_dual_port_io_with_comparators
